// ===== inc/twu_pkg.sv
// Purpose: shared constants and types of the 8-bit timer waveform output unit
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   register offsets are byte addresses on paddr

package twu_pkg;

    // apb address type
    typedef logic [7:0] twu_addr_t;

    // register offsets
    localparam twu_addr_t ADDR_CTRL    = 8'h00;
    localparam twu_addr_t ADDR_COUNT   = 8'h04;
    localparam twu_addr_t ADDR_COMPARE = 8'h08;
    localparam twu_addr_t ADDR_FLAGS   = 8'h0c;

    // control register fields
    localparam int CTRL_WGM_LSB   = 0;
    localparam int CTRL_COM_LSB   = 2;
    localparam int CTRL_FORCE_BIT = 4;

    // flag register fields
    localparam int FLAG_OVF_BIT   = 0;
    localparam int FLAG_CMP_BIT   = 1;
    localparam int FLAG_STATE_BIT = 2;

    // counter extremes
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // reset values
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic       RST_STATE   = 1'b0;

    // waveform generation modes
    typedef enum logic [1:0] {
        WGM_NORMAL = 2'b00,
        WGM_PHASE  = 2'b01,
        WGM_MATCH  = 2'b10,
        WGM_FAST   = 2'b11
    } twu_wgm_e;

    // compare output modes
    typedef enum logic [1:0] {
        COM_OFF    = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR  = 2'b10,
        COM_SET    = 2'b11
    } twu_com_e;

endpackage : twu_pkg

// ===== inc/twu_wave_if.sv
// Purpose: carries match events and modes from the counter to the output stage
// Assumes: all events are one-cycle pulses in the clk domain
// Notes:   oc_state is the registered compare output state

interface twu_wave_if;
    import twu_pkg::*;

    logic     match_evt;
    logic     bottom_evt;
    logic     force_evt;
    twu_wgm_e wgm;
    twu_com_e com;
    logic     oc_state;

    // counter side drives events, reads the state
    modport ctl  (output match_evt, bottom_evt, force_evt, wgm, com, input oc_state);
    // output stage reads events, drives the state
    modport wave (input match_evt, bottom_evt, force_evt, wgm, com, output oc_state);
endinterface : twu_wave_if

// ===== src/twu_wave.sv
// Purpose: compare output state register and its set, clear and toggle actions
// Assumes: match and bottom events come already qualified by the timer tick, force is a bus strobe
// Notes:   the state survives mode changes; only reset and the set, clear and toggle actions change it

module twu_wave (
    // clock and reset
    input wire logic   clk,
    input wire logic   sys_rst,
    // event and state link
    twu_wave_if.wave   wif
);
    import twu_pkg::*;

    logic oc_q;
    logic oc_d;

    // next state from the current modes and events
    always_comb begin
        oc_d = oc_q;
        case (wif.wgm)
            WGM_FAST: begin
                // match first, bottom last so a max compare holds steady
                if (wif.match_evt) begin
                    if (wif.com == COM_CLEAR) oc_d = 1'b0;
                    if (wif.com == COM_SET) oc_d = 1'b1;
                end
                // toggle setting does nothing here
                if (wif.bottom_evt) begin
                    if (wif.com == COM_CLEAR) oc_d = 1'b1;
                    if (wif.com == COM_SET) oc_d = 1'b0;
                end
            end
            WGM_PHASE: begin
                oc_d = oc_q;
            end
            default: begin
                // real or forced match, current field decides
                if (wif.match_evt || wif.force_evt) begin
                    case (wif.com)
                        COM_TOGGLE: oc_d = ~oc_q;
                        COM_CLEAR:  oc_d = 1'b0;
                        COM_SET:    oc_d = 1'b1;
                        default:    oc_d = oc_q;
                    endcase
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_q <= RST_STATE;
        end else begin
            oc_q <= oc_d;
        end
    end

    assign wif.oc_state = oc_q;

endmodule : twu_wave

// ===== src/twu_top.sv
// Purpose: 8-bit timer counter with compare match waveform output and APB
// Assumes: timer_tick is a one-cycle prescaled enable synchronous to clk
// Notes:   phase correct mode only counts up here and drives no output action
//          ctrl 0x00: [1:0] waveform mode, [3:2] output mode, [4] force strobe
//          count 0x04 and compare 0x08 hold bits [7:0]
//          compare reads back the pwm buffer
//          flags 0x0c: [0] overflow, [1] compare, write one clears
//          flags [2] shows the output state, read only

module twu_top (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire twu_pkg::twu_addr_t paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // prescaled count enable
    input  wire logic              timer_tick,
    // general purpose port pin
    input  wire logic              port_out_value,
    input  wire logic              output_pin_direction,
    output logic                   pin_out,
    output logic                   pin_oe,
    // status levels
    output logic                   overflow_flag,
    output logic                   compare_flag,
    output logic                   compare_output_state
);
    import twu_pkg::*;

    // control state
    twu_wgm_e    waveform_mode_q;
    twu_com_e    compare_output_mode_q;

    // counter and compare
    logic [7:0]  counter_value_q;
    logic [7:0]  counter_value_d;
    logic [7:0]  compare_buf_q;
    logic [7:0]  compare_value_q;

    // flags
    logic        overflow_flag_q;
    logic        compare_flag_q;
    logic        block_q;

    // bus decode
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_compare;
    logic        wr_flags;
    logic [31:0] rd_data;
    logic [31:0] prdata_q;

    // timer events
    logic        is_pwm;
    logic        at_max;
    logic        match_raw;
    logic        match_evt;
    logic        force_evt;
    twu_com_e    force_com;

    // link to the output stage
    twu_wave_if  wif ();

    // apb decode, zero wait states
    // pready is tied high, every access ends in its first access cycle
    // unmapped offsets drop writes, read zero and raise pslverr
    // read data come from a register loaded at setup
    assign access = psel && penable;
    assign wr_en  = access && pwrite;

    // mapped offsets
    // four words, all other offsets are holes
    always_comb begin
        case (paddr)
            ADDR_CTRL:    mapped = 1'b1;
            ADDR_COUNT:   mapped = 1'b1;
            ADDR_COMPARE: mapped = 1'b1;
            ADDR_FLAGS:   mapped = 1'b1;
            default:      mapped = 1'b0;
        endcase
    end

    // per-register write strobes
    // a write lands at the access edge
    assign wr_ctrl    = wr_en && (paddr == ADDR_CTRL);
    assign wr_count   = wr_en && (paddr == ADDR_COUNT);
    assign wr_compare = wr_en && (paddr == ADDR_COMPARE);
    assign wr_flags   = wr_en && (paddr == ADDR_FLAGS);

    // handshake answers
    // no wait states, error only in the access cycle
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // read mux, force bit always reads zero
    // upper bits always read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                rd_data[CTRL_WGM_LSB +: 2] = waveform_mode_q;
                rd_data[CTRL_COM_LSB +: 2] = compare_output_mode_q;
            end
            ADDR_COUNT: begin
                rd_data[7:0] = counter_value_q;
            end
            ADDR_COMPARE: begin
                rd_data[7:0] = compare_buf_q;
            end
            ADDR_FLAGS: begin
                rd_data[FLAG_OVF_BIT]   = overflow_flag_q;
                rd_data[FLAG_CMP_BIT]   = compare_flag_q;
                rd_data[FLAG_STATE_BIT] = wif.oc_state;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // read data caught in the setup cycle, held through access
    // prdata stays put until the next read setup
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_data;
        end
    end

    assign prdata = prdata_q;

    // control register
    // both mode fields load together on a control write
    // the new output mode steers the pin at once and the state from the next match or force on
    // the force bit is a strobe and never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waveform_mode_q       <= WGM_NORMAL;
            compare_output_mode_q <= COM_OFF;
        end else if (wr_ctrl) begin
            waveform_mode_q       <= twu_wgm_e'(pwdata[CTRL_WGM_LSB +: 2]);
            compare_output_mode_q <= twu_com_e'(pwdata[CTRL_COM_LSB +: 2]);
        end
    end

    // mode decode
    // low mode bit marks the two pwm modes
    assign is_pwm = waveform_mode_q[0];

    // force strobe only in non-pwm modes, uses the value just written
    assign force_evt = wr_ctrl && pwdata[CTRL_FORCE_BIT] && !is_pwm;

    // comparator and match qualification
    // the comparator looks at the active compare only
    // matches count on timer ticks alone
    // a counter write can mask the following tick
    assign at_max    = (counter_value_q == CNT_MAX);
    assign match_raw = (counter_value_q == compare_value_q);

    // match counts on a tick, unless a counter write blocked it
    // keeps a freshly written count from matching at once
    assign match_evt = timer_tick && match_raw && !block_q;

    // blocking window, open from a counter write until the next tick
    // also open while ticks are stopped
    // a write in a tick cycle keeps it open
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // counter sequence, waveform mode only
    // output mode never changes how the counter steps
    // a bus write to the counter wins over a tick
    // phase correct mode falls back to plain up counting
    always_comb begin
        counter_value_d = counter_value_q;
        if (timer_tick) begin
            case (waveform_mode_q)
                WGM_MATCH: begin
                    // compare is top; a low top makes it run to max and wrap
                    if (match_evt) begin
                        counter_value_d = CNT_BOTTOM;
                    end else begin
                        counter_value_d = counter_value_q + 8'h01;
                    end
                end
                WGM_FAST: begin
                    // single slope, max then bottom, 256 ticks a period
                    counter_value_d = counter_value_q + 8'h01;
                end
                default: begin
                    // normal: up only, natural wrap
                    counter_value_d = counter_value_q + 8'h01;
                end
            endcase
        end
    end

    // bus write beats every count operation
    // a tick in the write cycle is lost
    // reset brings the counter to bottom
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter_value_q <= RST_COUNT;
        end else if (wr_count) begin
            counter_value_q <= pwdata[7:0];
        end else begin
            counter_value_q <= counter_value_d;
        end
    end

    // compare value, buffered in pwm modes
    // software always reads back the buffer
    // non-pwm writes reach the comparator at once
    // pwm writes wait for the max to bottom step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_buf_q <= RST_COMPARE;
        end else if (wr_compare) begin
            compare_buf_q <= pwdata[7:0];
        end
    end

    // active compare, direct in non-pwm, loaded at max to bottom in pwm
    // the buffer holds the pending pwm value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_value_q <= RST_COMPARE;
        end else if (wr_compare && !is_pwm) begin
            compare_value_q <= pwdata[7:0];
        end else if (is_pwm && timer_tick && at_max) begin
            compare_value_q <= compare_buf_q;
        end
    end

    // flags, write one to clear, a set in the same cycle wins
    // counting only ever sets a flag
    // a forced match never touches the compare flag
    // clearing is left to software writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overflow_flag_q <= 1'b0;
        end else if (timer_tick && at_max) begin
            // max to bottom wrap in every waveform mode, phase correct included
            overflow_flag_q <= 1'b1;
        end else if (wr_flags && pwdata[FLAG_OVF_BIT]) begin
            overflow_flag_q <= 1'b0;
        end
    end

    // compare flag, never from a forced match
    // set at the tick that sees the equal count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_flag_q <= 1'b0;
        end else if (match_evt) begin
            compare_flag_q <= 1'b1;
        end else if (wr_flags && pwdata[FLAG_CMP_BIT]) begin
            compare_flag_q <= 1'b0;
        end
    end

    // flags leave as plain levels
    assign overflow_flag = overflow_flag_q;
    assign compare_flag  = compare_flag_q;

    // output stage link
    // match and bottom events are already qualified by the timer tick, a force is not
    // bottom only matters in fast mode
    // a force uses the output mode written with it
    assign wif.match_evt  = match_evt;
    assign wif.bottom_evt = timer_tick && at_max && (waveform_mode_q == WGM_FAST);
    assign wif.force_evt  = force_evt;
    assign wif.wgm        = waveform_mode_q;
    assign force_com      = twu_com_e'(pwdata[CTRL_COM_LSB +: 2]);
    assign wif.com        = force_evt ? force_com : compare_output_mode_q;

    twu_wave u_wave (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wif     (wif)
    );

    // internal state also leaves as a level
    assign compare_output_state = wif.oc_state;

    // port override, direction stays with the port
    // override needs only a nonzero output mode
    // waveform mode plays no part in the choice
    // the pin driver stays under the port direction bit
    // state may be set while the pin is still an input
    assign pin_out = (compare_output_mode_q != COM_OFF) ? wif.oc_state
                                                         : port_out_value;
    assign pin_oe  = output_pin_direction;

endmodule : twu_top

// ===== tb/twu_top_props.sv
// Purpose: port level checks of the timer waveform output unit
// Assumes: zero wait apb, mode fields followed from control writes
// Notes:   bound to twu_top after the module
module twu_top_props (
    // clock and reset
    input wire logic               clk,
    input wire logic               sys_rst,
    // apb slave
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire twu_pkg::twu_addr_t paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    input wire logic [31:0]        prdata,
    input wire logic               pslverr,
    // timer, pin and status
    input wire logic               timer_tick,
    input wire logic               port_out_value,
    input wire logic               output_pin_direction,
    input wire logic               pin_out,
    input wire logic               pin_oe,
    input wire logic               overflow_flag,
    input wire logic               compare_flag,
    input wire logic               compare_output_state
);
    timeunit 1ns;
    timeprecision 1ps;
    import twu_pkg::*;
    logic       ctrl_wr;
    logic       flag_wr;
    logic       frc_ok;
    logic       frc_exp;
    logic [1:0] com_q;
    logic [1:0] wgm_q;

    // decoded writes; force only counts in modes 0 and 2 with no tick
    assign ctrl_wr = psel && penable && pwrite && pready && (paddr == ADDR_CTRL);
    assign flag_wr = psel && penable && pwrite && pready && (paddr == ADDR_FLAGS);
    assign frc_ok  = ctrl_wr && pwdata[CTRL_FORCE_BIT] && !pwdata[CTRL_WGM_LSB]
                     && !wgm_q[0] && !timer_tick;

    // state expected from a forced match with the new output mode
    always_comb begin
        case (pwdata[CTRL_COM_LSB +: 2])
            2'h1:    frc_exp = !compare_output_state;
            2'h2:    frc_exp = 1'h0;
            2'h3:    frc_exp = 1'h1;
            default: frc_exp = compare_output_state;
        endcase
    end

    // shadow of the mode fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            com_q <= 2'h0;
            wgm_q <= 2'h0;
        end else if (ctrl_wr) begin
            com_q <= pwdata[CTRL_COM_LSB +: 2];
            wgm_q <= pwdata[CTRL_WGM_LSB +: 2];
        end
    end

    rst_clear_a: assert property (@(posedge clk)
        sys_rst |=> !compare_output_state && !overflow_flag && !compare_flag)
        else $error("reset left state or flags set");
    pin_mux_a: assert property (@(posedge clk) disable iff (sys_rst)
        pin_out == ((com_q != 2'h0) ? compare_output_state : port_out_value))
        else $error("pin value source wrong");
    pin_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
        pin_oe == output_pin_direction)
        else $error("pin enable not following direction");
    off_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (com_q == 2'h0 && !ctrl_wr) |=> $stable(compare_output_state))
        else $error("state moved with output mode off");
    force_act_a: assert property (@(posedge clk) disable iff (sys_rst)
        frc_ok |=> !$rose(compare_flag) && compare_output_state == $past(frc_exp))
        else $error("forced match result wrong");
    fast_resv_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wgm_q == 2'h3 && com_q == 2'h1 && !ctrl_wr) |=> $stable(compare_output_state))
        else $error("reserved fast setting moved state");
    flag_tick_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(compare_flag) || $rose(overflow_flag)) |-> $past(timer_tick))
        else $error("flag set without timer tick");
    ovf_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        (overflow_flag && !flag_wr) |=> overflow_flag)
        else $error("overflow flag dropped by counting");
    cmp_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        (compare_flag && !flag_wr) |=> compare_flag)
        else $error("compare flag dropped by counting");
endmodule : twu_top_props

bind twu_top twu_top_props twu_top_props_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timer_tick(timer_tick),
    .port_out_value(port_out_value), .output_pin_direction(output_pin_direction),
    .pin_out(pin_out), .pin_oe(pin_oe), .overflow_flag(overflow_flag),
    .compare_flag(compare_flag), .compare_output_state(compare_output_state));

// ===== tb/twu_port_model.sv
// Purpose: general purpose port pin facing the waveform unit
// Assumes: the pad has a pull-up while no driver is enabled
// Notes:   software view of port value and direction comes from the bench
module twu_port_model (
    // software view of the port
    input  wire logic sw_value,
    input  wire logic sw_dir,
    // port side of the unit
    output logic      port_out_value,
    output logic      output_pin_direction,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    // resolved pad level
    output logic      pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // port register and direction bit, set by software before enabling
    assign port_out_value       = sw_value;
    assign output_pin_direction = sw_dir;
    // pad follows the driver only while enabled, else the pull-up
    assign pad = pin_oe ? pin_out : 1'h1;
endmodule : twu_port_model

// ===== tb/tb.sv
// Purpose: self-checking bench of the timer waveform output unit
// Assumes: zero wait apb slave, ticks driven by the bench
// Notes:   one task per scenario, verdict printed by conclude
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import twu_pkg::*;
    logic        clk, sys_rst, psel, penable, pwrite, timer_tick;
    logic        sw_value, sw_dir, pad, pready, pslverr, pin_out, pin_oe, err;
    logic        port_out_value, output_pin_direction, ovf, cmp, st;
    twu_addr_t   paddr;
    logic [31:0] pwdata, prdata, rd;
    int          fails, checks_done;

    // design and port model
    twu_top twu_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_tick(timer_tick), .port_out_value(port_out_value),
        .output_pin_direction(output_pin_direction), .pin_out(pin_out), .pin_oe(pin_oe),
        .overflow_flag(ovf), .compare_flag(cmp), .compare_output_state(st));
    twu_port_model twu_port_model_i (.sw_value(sw_value), .sw_dir(sw_dir),
        .port_out_value(port_out_value), .output_pin_direction(output_pin_direction),
        .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input twu_addr_t a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20) begin
            fails++;
            conclude();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask : apb

    task automatic wr(input twu_addr_t a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input string nm, input twu_addr_t a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdc

    // n timer ticks seen by the design, then settle
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            timer_tick <= 1'h1;
        end
        @(posedge clk);
        timer_tick <= 1'h0;
        #1;
    endtask : tick

    task automatic t_reset;
        chk("state", 32'h0, 32'(st));
        chk("flags", 32'h0, 32'({ovf, cmp}));
        rdc("ctrl", ADDR_CTRL, 32'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        $display("test reset done");
    endtask : t_reset

    task automatic t_normal;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_COUNT, 32'hfe);
        tick(1);
        chk("ovf", 32'h0, 32'(ovf));
        tick(1);
        chk("ovf", 32'h1, 32'(ovf));
        rdc("count", ADDR_COUNT, 32'h0);
        wr(ADDR_COMPARE, 32'h10);
        wr(ADDR_COUNT, 32'h10);
        wr(ADDR_FLAGS, 32'h3);
        tick(1);
        chk("cmp", 32'h0, 32'(cmp));
        $display("test normal done");
    endtask : t_normal

    task automatic t_clear;
        logic s;
        wr(ADDR_COMPARE, 32'h2);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_CTRL, 32'h6);
        s = st;
        tick(2);
        chk("state", 32'(s), 32'(st));
        rdc("count", ADDR_COUNT, 32'h2);
        tick(1);
        chk("state", 32'(!s), 32'(st));
        chk("cmp", 32'h1, 32'(cmp));
        rdc("count", ADDR_COUNT, 32'h0);
        tick(3);
        chk("state", 32'(s), 32'(st));
        $display("test clear on match done");
    endtask : t_clear

    task automatic t_miss;
        wr(ADDR_COUNT, 32'h5);
        wr(ADDR_COMPARE, 32'h3);
        wr(ADDR_FLAGS, 32'h3);
        tick(251);
        chk("cmp", 32'h0, 32'(cmp));
        chk("ovf", 32'h1, 32'(ovf));
        tick(4);
        chk("cmp", 32'h1, 32'(cmp));
        rdc("count", ADDR_COUNT, 32'h0);
        $display("test missed match done");
    endtask : t_miss

    task automatic t_force;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_CTRL, 32'h1c);
        chk("state", 32'h1, 32'(st));
        wr(ADDR_CTRL, 32'h18);
        chk("state", 32'h0, 32'(st));
        chk("pad", 32'h1, 32'(pad));
        @(posedge clk);
        sw_dir <= 1'h1;
        wr(ADDR_CTRL, 32'h14);
        chk("state", 32'h1, 32'(st));
        chk("cmp", 32'h0, 32'(cmp));
        chk("pad", 32'h1, 32'(pad));
        wr(ADDR_CTRL, 32'h0);
        chk("pin", 32'(sw_value), 32'(pin_out));
        wr(ADDR_CTRL, 32'hf);
        chk("pin", 32'h1, 32'(pin_out));
        $display("test force done");
    endtask : t_force

    task automatic t_fast;
        logic s;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_COMPARE, 32'h80);
        wr(ADDR_COUNT, 32'h7e);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_CTRL, 32'hb);
        tick(2);
        chk("state", 32'h1, 32'(st));
        tick(1);
        chk("state", 32'h0, 32'(st));
        wr(ADDR_COMPARE, 32'h90);
        tick(126);
        chk("ovf", 32'h0, 32'(ovf));
        rdc("count", ADDR_COUNT, 32'hff);
        tick(1);
        chk("state", 32'h1, 32'(st));
        chk("ovf", 32'h1, 32'(ovf));
        tick(136);
        chk("state", 32'h1, 32'(st));
        tick(9);
        chk("state", 32'h0, 32'(st));
        wr(ADDR_CTRL, 32'h7);
        s = st;
        tick(256);
        chk("state", 32'(s), 32'(st));
        wr(ADDR_COMPARE, 32'hff);
        wr(ADDR_CTRL, 32'hb);
        tick(111);
        chk("state", 32'h1, 32'(st));
        tick(256);
        chk("state", 32'h1, 32'(st));
        $display("test fast done");
    endtask : t_fast

    // free running clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // reset, then every scenario in turn
    initial begin
        sys_rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        timer_tick = 1'h0;
        sw_value = 1'h0;
        sw_dir = 1'h0;
        fails = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset();
        t_normal();
        t_clear();
        t_miss();
        t_force();
        t_fast();
        conclude();
    end
endmodule : tb
